// *** rtl/pbac_pkg.sv ***
`default_nettype none

package pbac_pkg;

	localparam logic [11:0] OFS_DATA_SEL = 12'h210;
	localparam logic [11:0] OFS_PB_DATA = 12'h214;
	localparam logic [11:0] OFS_PB_CAP = 12'h218;
	localparam logic [11:0] OFS_ACS_HDR = 12'h220;
	localparam logic [11:0] OFS_ACS_CTRL = 12'h224;
	localparam logic [11:0] OFS_EGRESS = 12'h228;

	localparam int BASE_LSB = 0;
	localparam int SCALE_LSB = 8;
	localparam int SUB_LSB = 10;
	localparam int PMST_LSB = 13;
	localparam int TYPE_LSB = 15;
	localparam int RAIL_LSB = 18;
	localparam int SUPP_LSB = 0;
	localparam int VSIZE_LSB = 8;
	localparam int EN_LSB = 16;
	localparam int EN_EGRESS_BIT = 5;

	localparam logic [7:0] RST_BASE_POWER = 8'h04;
	localparam logic [1:0] RST_SCALE = 2'h0;
	localparam logic [2:0] RST_SUB_STATE = 3'h0;
	localparam logic [1:0] RST_PM_STATE = 2'h0;
	localparam logic [2:0] RST_TYPE_MAX = 3'h7;
	localparam logic [2:0] RST_RAIL = 3'h2;
	localparam logic [0:0] RST_SYS_ALLOC = 1'h0;
	localparam logic [7:0] RST_DATA_SEL = 8'h00;

	localparam logic [7:0] SEL_D0_MAX = 8'h00;
	localparam logic [7:0] SEL_D0_SUST = 8'h01;

	localparam logic [15:0] ACS_CAP_ID = 16'h000d;
	localparam logic [3:0] ACS_CAP_VER = 4'h1;
	localparam logic [11:0] ACS_NEXT_PTR = 12'h240;
	localparam logic [6:0] RST_ACS_SUPP = 7'h7f;
	localparam logic [7:0] RST_VEC_SIZE = 8'h08;
	localparam logic [6:0] RST_ACS_EN = 7'h00;
	localparam logic [7:0] RST_EGRESS = 8'h00;

	typedef enum logic [1:0] {
		PBAC_ST_STRAP = 2'b01,
		PBAC_ST_RUN = 2'b10
	} pbac_state_t;

endpackage

`default_nettype wire

// *** rtl/pbac_preload_field.sv ***
`default_nettype none

module pbac_preload_field #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic [W-1:0] q
);

	logic [W-1:0] field_q;
	logic [W-1:0] field_d;

	// Software cannot write this field; only the preload path replaces it
	always_comb begin
		field_d = field_q;
		if (load) begin
			field_d = value;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			field_q <= RST;
		end else begin
			field_q <= field_d;
		end
	end

	assign q = field_q;

endmodule

`default_nettype wire

// *** rtl/pbac_regs.sv ***
`default_nettype none

module pbac_regs #(
	parameter logic [2:0] SUST_TYPE = 3'h1
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic port_is_downstream,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic pre_load,
	input wire logic [7:0] pre_base_power,
	input wire logic [1:0] pre_scale,
	input wire logic [1:0] pre_pm_state,
	input wire logic pre_sys_alloc,
	output logic downstream_port,
	output logic [6:0] acs_enable,
	output logic [7:0] egress_block
);

	////////////////////////////////////////////////////////////////////////
	// Preloadable read-only defaults

	logic [7:0] base_power;
	logic [1:0] data_scale;
	logic [1:0] pm_state;
	logic [0:0] sys_alloc;

	pbac_preload_field #(
		.W(8),
		.RST(pbac_pkg::RST_BASE_POWER)
	) u_base_power (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.load(pre_load),
		.value(pre_base_power),
		.q(base_power)
	);

	pbac_preload_field #(
		.W(2),
		.RST(pbac_pkg::RST_SCALE)
	) u_data_scale (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.load(pre_load),
		.value(pre_scale),
		.q(data_scale)
	);

	pbac_preload_field #(
		.W(2),
		.RST(pbac_pkg::RST_PM_STATE)
	) u_pm_state (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.load(pre_load),
		.value(pre_pm_state),
		.q(pm_state)
	);

	pbac_preload_field #(
		.W(1),
		.RST(pbac_pkg::RST_SYS_ALLOC)
	) u_sys_alloc (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.load(pre_load),
		.value(pre_sys_alloc),
		.q(sys_alloc)
	);

	////////////////////////////////////////////////////////////////////////
	// Port role strap

	pbac_pkg::pbac_state_t state_q;
	pbac_pkg::pbac_state_t state_d;
	logic ds_q;
	logic ds_d;

	// The strap is caught one edge after reset release, never under reset
	always_comb begin
		state_d = state_q;
		ds_d = ds_q;
		case (state_q)
			pbac_pkg::PBAC_ST_STRAP: begin
				ds_d = port_is_downstream;
				state_d = pbac_pkg::PBAC_ST_RUN;
			end
			pbac_pkg::PBAC_ST_RUN: begin
				ds_d = ds_q;
			end
			default: begin
				state_d = pbac_pkg::PBAC_ST_STRAP;
				ds_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q <= pbac_pkg::PBAC_ST_STRAP;
			ds_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ds_q <= ds_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Writable state

	logic [7:0] data_sel_q;
	logic [7:0] data_sel_d;
	logic [6:0] acs_en_q;
	logic [6:0] acs_en_d;
	logic [7:0] egress_q;
	logic [7:0] egress_d;
	logic [7:0] egress_blk_q;
	logic [7:0] egress_blk_d;
	logic wr_sel;
	logic wr_ctrl;
	logic wr_egr;

	always_comb begin
		wr_sel = reg_wr && (reg_addr == pbac_pkg::OFS_DATA_SEL);
		// Upstream port has no ACS registers: writes there fall away
		wr_ctrl = reg_wr && ds_q && (reg_addr == pbac_pkg::OFS_ACS_CTRL);
		wr_egr = reg_wr && ds_q && (reg_addr == pbac_pkg::OFS_EGRESS);
	end

	always_comb begin
		data_sel_d = data_sel_q;
		acs_en_d = acs_en_q;
		egress_d = egress_q;
		if (wr_sel) begin
			data_sel_d = reg_wdata[7:0];
		end
		if (wr_ctrl) begin
			// Only bits 22:16 take the write; the rest are fixed or reserved
			acs_en_d = reg_wdata[pbac_pkg::EN_LSB +: 7];
		end
		if (wr_egr) begin
			egress_d = reg_wdata[7:0];
		end
		// Vector is inert until peer egress control is enabled
		if (acs_en_d[pbac_pkg::EN_EGRESS_BIT]) begin
			egress_blk_d = egress_d;
		end else begin
			egress_blk_d = 8'h00;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			data_sel_q <= pbac_pkg::RST_DATA_SEL;
			acs_en_q <= pbac_pkg::RST_ACS_EN;
			egress_q <= pbac_pkg::RST_EGRESS;
			egress_blk_q <= pbac_pkg::RST_EGRESS;
		end else begin
			data_sel_q <= data_sel_d;
			acs_en_q <= acs_en_d;
			egress_q <= egress_d;
			egress_blk_q <= egress_blk_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read image of each register

	logic [31:0] img_data;
	logic [31:0] img_cap;
	logic [31:0] img_hdr;
	logic [31:0] img_ctrl;
	logic [31:0] img_egr;

	always_comb begin
		img_data = 32'h0000_0000;
		// Any index other than the two D0 entries reports a zero budget
		if (data_sel_q == pbac_pkg::SEL_D0_MAX || data_sel_q == pbac_pkg::SEL_D0_SUST) begin
			img_data[pbac_pkg::BASE_LSB +: 8] = base_power;
			img_data[pbac_pkg::SCALE_LSB +: 2] = data_scale;
			img_data[pbac_pkg::SUB_LSB +: 3] = pbac_pkg::RST_SUB_STATE;
			img_data[pbac_pkg::PMST_LSB +: 2] = pm_state;
			img_data[pbac_pkg::TYPE_LSB +: 3] = pbac_pkg::RST_TYPE_MAX;
			img_data[pbac_pkg::RAIL_LSB +: 3] = pbac_pkg::RST_RAIL;
			if (data_sel_q == pbac_pkg::SEL_D0_SUST) begin
				img_data[pbac_pkg::TYPE_LSB +: 3] = SUST_TYPE;
			end
		end
	end

	always_comb begin
		img_cap = 32'h0000_0000;
		img_cap[0] = sys_alloc[0];
	end

	always_comb begin
		img_hdr = 32'h0000_0000;
		img_ctrl = 32'h0000_0000;
		img_egr = 32'h0000_0000;
		if (ds_q) begin
			img_hdr = {pbac_pkg::ACS_NEXT_PTR, pbac_pkg::ACS_CAP_VER,
				pbac_pkg::ACS_CAP_ID};
			img_ctrl[pbac_pkg::SUPP_LSB +: 7] = pbac_pkg::RST_ACS_SUPP;
			img_ctrl[pbac_pkg::VSIZE_LSB +: 8] = pbac_pkg::RST_VEC_SIZE;
			img_ctrl[pbac_pkg::EN_LSB +: 7] = acs_en_q;
			img_egr[7:0] = egress_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port: data stand only in the cycle after the strobe

	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				pbac_pkg::OFS_DATA_SEL: rdata_d = {24'h000000, data_sel_q};
				pbac_pkg::OFS_PB_DATA: rdata_d = img_data;
				pbac_pkg::OFS_PB_CAP: rdata_d = img_cap;
				pbac_pkg::OFS_ACS_HDR: rdata_d = img_hdr;
				pbac_pkg::OFS_ACS_CTRL: rdata_d = img_ctrl;
				pbac_pkg::OFS_EGRESS: rdata_d = img_egr;
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign downstream_port = ds_q;
	assign acs_enable = acs_en_q;
	assign egress_block = egress_blk_q;

endmodule

`default_nettype wire

// *** sim/pbac_regs_chk.sv ***
`default_nettype none

module pbac_regs_chk (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_rdata,
	input wire logic downstream_port,
	input wire logic [6:0] acs_enable,
	input wire logic [7:0] egress_block
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////
	a_hdr_value: assert property ($past(reg_rd) && $past(downstream_port) &&
		$past(reg_addr) == 12'h220 |-> reg_rdata == 32'h2401000d) else $error("bad header");
	a_up_hidden: assert property ($past(reg_rd) && !$past(downstream_port) &&
		$past(reg_addr) inside {12'h220, 12'h224, 12'h228} |-> reg_rdata == 32'h0)
		else $error("upstream ACS visible");
	a_cap_fixed: assert property ($past(reg_rd) && $past(downstream_port) &&
		$past(reg_addr) == 12'h224 |-> reg_rdata[15:0] == 16'h087f && reg_rdata[31:23] == 9'h0)
		else $error("bad capability bits");
	a_en_echo: assert property ($past(reg_rd) && $past(downstream_port) &&
		$past(reg_addr) == 12'h224 |-> reg_rdata[22:16] == $past(acs_enable))
		else $error("enable readback differs");
	a_vec_echo: assert property ($past(reg_rd) && $past(downstream_port) &&
		$past(reg_addr) == 12'h228 |-> reg_rdata[31:8] == 24'h0 &&
		$past(egress_block) == ($past(acs_enable[5]) ? reg_rdata[7:0] : 8'h00))
		else $error("egress vector mismatch");
	a_egress_gate: assert property (egress_block != 8'h00 |-> acs_enable[5])
		else $error("blocking without enable");
	a_data_rsvd: assert property ($past(reg_rd) && $past(reg_addr) == 12'h214
		|-> reg_rdata[31:21] == 11'h0) else $error("data reserved set");
	a_alloc_only: assert property ($past(reg_rd) && $past(reg_addr) == 12'h218
		|-> reg_rdata[31:1] == 31'h0) else $error("capability reserved set");
	// Strap is taken once; a later change would move the ACS block away under software
	a_strap_hold: assert property ($past(nrst) && $past(nrst, 2) |->
		$stable(downstream_port)) else $error("strap changed");
	// Read data stand only in the cycle after the strobe, zero at all other times
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its cycle");
endmodule

`default_nettype wire

// *** sim/tb_top.sv ***
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, nrst = 1'b0, port_is_downstream = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0, pre_load = 1'b0, pre_sys_alloc = 1'b0;
	logic [11:0] reg_addr = 12'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [7:0] pre_base_power = 8'h0, egress_block;
	logic [1:0] pre_scale = 2'h0, pre_pm_state = 2'h0;
	logic [6:0] acs_enable, en;
	logic downstream_port, ds, sa;
	logic [7:0] sel, base, vec;
	logic [1:0] scale, pm;
	int err_count = 0, checks = 0;
	logic [11:0] adr [8] = '{12'h210, 12'h214, 12'h218, 12'h220, 12'h224, 12'h228, 12'h22c, 12'h000};

	pbac_regs dut (.clk_sys(clk_sys), .nrst(nrst), .port_is_downstream(port_is_downstream),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pre_load(pre_load), .pre_base_power(pre_base_power),
		.pre_scale(pre_scale), .pre_pm_state(pre_pm_state), .pre_sys_alloc(pre_sys_alloc),
		.downstream_port(downstream_port), .acs_enable(acs_enable), .egress_block(egress_block));

	initial forever #25ns clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	task automatic chk(string n, logic [31:0] g, logic [31:0] e);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [31:0] exp_rd(logic [11:0] a);
		logic [31:0] r;
		r = 32'h0;
		case (a)
			12'h210: r = {24'h0, sel};
			12'h214: if (sel < 8'h02) r = {11'h0, 3'h2, sel[0] ? 3'h1 : 3'h7, pm, 3'h0, scale, base};
			12'h218: r = {31'h0, sa};
			12'h220: if (ds) r = 32'h2401000d;
			12'h224: if (ds) r = {9'h0, en, 8'h08, 1'b0, 7'h7f};
			12'h228: if (ds) r = {24'h0, vec};
			default: r = 32'h0;
		endcase
		return r;
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic rd(logic [11:0] a);
		logic [31:0] e;
		logic [31:0] g;
		e = exp_rd(a);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 g = reg_rdata;
		chk("rd_b0", g & 32'hff, e & 32'hff);
		chk("rd_b1", g & 32'hff00, e & 32'hff00);
		chk("rd_b2", g & 32'hff0000, e & 32'hff0000);
		chk("rd_b3", g & 32'hff000000, e & 32'hff000000);
	endtask

	task automatic wr(logic [11:0] a, logic [31:0] d);
		if (a == 12'h210) d[7:0] = 8'($urandom % 3);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		if (a == 12'h210) sel = d[7:0];
		if (ds && a == 12'h224) en = d[22:16];
		if (ds && a == 12'h228) vec = d[7:0];
		#1 chk("acs_enable", {25'h0, acs_enable}, {25'h0, en});
		chk("egress_block", {24'h0, egress_block}, {24'h0, en[5] ? vec : 8'h00});
		chk("downstream_port", {31'h0, downstream_port}, {31'h0, ds});
	endtask

	task automatic pre();
		logic [12:0] v;
		v = 13'($urandom);
		@(posedge clk_sys);
		pre_load <= 1'b1;
		{pre_sys_alloc, pre_pm_state, pre_scale, pre_base_power} <= v;
		{sa, pm, scale, base} = v;
		@(posedge clk_sys);
		pre_load <= 1'b0;
	endtask

	// Reset also clears the preloaded defaults, so the model starts over
	task automatic run(logic d);
		@(posedge clk_sys);
		nrst <= 1'b0;
		port_is_downstream <= d;
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		{ds, sel, en, vec, base, scale, pm, sa} = {d, 8'h00, 7'h00, 8'h00, 8'h04, 2'h0, 2'h0, 1'b0};
		foreach (adr[i]) rd(adr[i]);
		// A strap that moves after capture must not move the ACS block
		@(posedge clk_sys);
		port_is_downstream <= ~d;
		for (int n = 0; n < 120; n++) begin
			case ($urandom % 3)
				0: wr(adr[$urandom % 8], $urandom);
				1: rd(adr[$urandom % 8]);
				default: pre();
			endcase
		end
		foreach (adr[i]) rd(adr[i]);
	endtask

	task automatic results();
		if (err_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h967c));
		run(1'b1);
		run(1'b0);
		results();
	end

	// About 600 cycles are needed; far more is allowed before calling it a hang
	initial begin
		#(50ns * 20000);
		err_count++;
		results();
	end
endmodule

bind pbac_regs pbac_regs_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_rdata(reg_rdata), .downstream_port(downstream_port),
	.acs_enable(acs_enable), .egress_block(egress_block));

`default_nettype wire
